/* inc/fpep_consts.vh */
// constants for the flash program/erase protection block
// Notes on behaviour
// - write-enable pin low clears control one and block select, refuses program/erase/verify.
// - any reset or standby clears control one and block select; control two too, except on software standby; protected state.
// - hardware protection makes every block unerasable, ignoring block selection.
// - write-enable pin protection drops the RAM overlay.
// - malfunction while programming/erasing sets error flag and aborts mode at once.
// - error state keeps registers, pulse bits writable, never enters program/erase.
// - error state still allows program-verify and erase-verify.
// - flash read while pulse bit set raises error flag.
// - exception start while pulse set raises error, except reset/illegal/trap/divide.
// - sleep or software standby while pulse set raises error flag.
// - bus granted to another master while pulse set raises error flag.
// - error state released only by pin reset, watchdog reset or hardware standby.
// - in error state control one and block select writable; cleared by software standby.
// - error detection armed only while pulse bit set; non-maskable interrupt blocked then.
// - erase only on selected blocks; programming unrestricted by selection; verify allowed.
// - block select zero protects every block against erase.
// - overlay select bit protects all blocks, ignores pulse bits; verify, RAM writes allowed.
// - RAM window FFF000..FFF3FF maps onto small block picked by RAM control bits 2..0.
// - overlaid RAM cells reachable at flash and original RAM addresses.
// - pulse bits cleared on reset, standby, pin low, or software enable zero.
`ifndef FPEP_CONSTS_VH
`define FPEP_CONSTS_VH
// ************************************************************
// register byte addresses
// ************************************************************
`define FPEP_ADDR_CTRL1   4'h0
`define FPEP_ADDR_CTRL2   4'h1
`define FPEP_ADDR_EBSEL   4'h2
`define FPEP_ADDR_RAM_CONTROL_REG   4'h3
`define FPEP_ADDR_EVENT   4'h4
// ************************************************************
// control one fields
// ************************************************************
`define FPEP_C1_P         0
`define FPEP_C1_E         1
`define FPEP_C1_PV        2
`define FPEP_C1_EV        3
`define FPEP_C1_PSU       4
`define FPEP_C1_ESU       5
`define FPEP_C1_SWE       6
`define FPEP_C1_FWE       7
`define FPEP_C1_WMASK     8'h7f
// ************************************************************
// control two / status fields
// ************************************************************
`define FPEP_C2_FLASH_ERROR_FLAG      7
// ************************************************************
// RAM control fields
// ************************************************************
`define FPEP_RC_RAM_OVERLAY_SELECT      3
`define FPEP_RC_SEL_HI    2
`define FPEP_RC_SEL_LO    0
`define FPEP_RC_WMASK     8'h0f
// ************************************************************
// event register fields
// ************************************************************
`define FPEP_EV_SWSTBY    0
`define FPEP_EV_HWSTBY    1
`define FPEP_EV_SLEEP     2
// ************************************************************
// address map
// ************************************************************
`define FPEP_RAM_WIN_BASE 24'hfff000
`define FPEP_RAM_WIN_TOP  24'hfff3ff
`define FPEP_WIN_SHIFT    10
`define FPEP_RESET_VAL    8'h00
`endif

/* core/fpep_protect.v */
// flash program/erase protection and RAM overlay logic
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fpep_consts.vh"

module fpep_protect #(
    parameter NUM_BLOCKS     = 8,
    parameter SMALL_BLOCK_LO = 0
) (
    // clock and reset
    input  wire                   clock,
    input  wire                   arst_n,
    input  wire                   watchdog_timer_reset,
    // avalon-mm slave
    input  wire [3:0]             avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output wire                   avs_waitrequest,
    // pins and cpu events
    input  wire                   flash_write_enable_pin,
    input  wire                   hw_standby,
    input  wire                   flash_read,
    input  wire                   exception_start,
    input  wire                   exception_excluded,
    input  wire                   sleep_exec,
    input  wire                   bus_granted,
    input  wire                   nmi_in,
    // cpu address for overlay
    input  wire [23:0]            cpu_addr,
    // flash side
    output reg                    program_mode,
    output reg                    erase_mode,
    output reg                    program_verify_mode,
    output reg                    erase_verify_mode,
    output reg  [NUM_BLOCKS-1:0]  erase_enable,
    output wire                   nmi_out,
    output wire                   overlay_hit,
    output wire [9:0]             overlay_offset
);
    // ************************************************************
    // reset synchroniser
    // ************************************************************
    reg  sync_a;
    reg  sync_b;
    wire rst_n;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= 1'b1;
            sync_b <= sync_a;
        end
    end
    assign rst_n = sync_b;

    // ************************************************************
    // registers
    // ************************************************************
    reg  [7:0]            flash_control_reg_one;
    reg  [7:0]            flash_control_reg_two;
    reg  [NUM_BLOCKS-1:0] erase_block_select;
    reg  [7:0]            ram_control_reg;
    reg                   sw_standby;
    reg                   hw_standby_sw;
    reg                   rd_pending;
    wire                  flash_error_flag;
    wire                  ram_overlay_select;
    wire                  software_write_enable_bit;
    wire                  pulse_set;
    wire                  error_event;
    wire                  pin_low;
    wire                  standby;
    wire                  wr_ok;
    wire [7:0]            wbyte;

    assign flash_error_flag          = flash_control_reg_two[`FPEP_C2_FLASH_ERROR_FLAG];
    assign ram_overlay_select        = ram_control_reg[`FPEP_RC_RAM_OVERLAY_SELECT];
    assign software_write_enable_bit = flash_control_reg_one[`FPEP_C1_SWE];
    assign pin_low                   = !flash_write_enable_pin;
    assign standby                   = sw_standby | hw_standby | hw_standby_sw;
    assign pulse_set = flash_control_reg_one[`FPEP_C1_P] | flash_control_reg_one[`FPEP_C1_E];
    assign wr_ok     = avs_write & avs_byteenable[0];
    assign wbyte     = avs_writedata[7:0];

    // one wait state on reads, writes immediate
    assign avs_waitrequest = avs_read & !rd_pending;

    // error conditions only while a pulse bit is set
    assign error_event = pulse_set & (flash_read
                       | (exception_start & !exception_excluded)
                       | sleep_exec | sw_standby
                       | bus_granted);

    // non-maskable interrupt blocked while pulsing or in error state
    assign nmi_out = nmi_in & !pulse_set & !flash_error_flag;

    // ************************************************************
    // control one and block select
    // ************************************************************
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_control_reg_one <= `FPEP_RESET_VAL;
            erase_block_select    <= {NUM_BLOCKS{1'b0}};
        end else if (pin_low || standby || watchdog_timer_reset) begin
            flash_control_reg_one <= `FPEP_RESET_VAL;
            erase_block_select    <= {NUM_BLOCKS{1'b0}};
        end else begin
            if (wr_ok && avs_address == `FPEP_ADDR_CTRL1) begin
                // pulse bits writable even in error state
                flash_control_reg_one <= wbyte & `FPEP_C1_WMASK;
                if (!wbyte[`FPEP_C1_SWE]) begin
                    flash_control_reg_one[`FPEP_C1_P] <= 1'b0;
                    flash_control_reg_one[`FPEP_C1_E] <= 1'b0;
                end
            end else if (!software_write_enable_bit) begin
                flash_control_reg_one[`FPEP_C1_P] <= 1'b0;
                flash_control_reg_one[`FPEP_C1_E] <= 1'b0;
            end
            if (wr_ok && avs_address == `FPEP_ADDR_EBSEL) begin
                erase_block_select <= avs_writedata[NUM_BLOCKS-1:0];
            end
        end
    end

    // ************************************************************
    // control two, error flag
    // ************************************************************
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_control_reg_two <= `FPEP_RESET_VAL;
        end else if (watchdog_timer_reset || hw_standby || hw_standby_sw) begin
            flash_control_reg_two <= `FPEP_RESET_VAL;
        end else if (error_event) begin
            flash_control_reg_two[`FPEP_C2_FLASH_ERROR_FLAG] <= 1'b1;
        end
    end

    // ************************************************************
    // RAM control and standby event register
    // ************************************************************
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ram_control_reg <= `FPEP_RESET_VAL;
            sw_standby      <= 1'b0;
            hw_standby_sw   <= 1'b0;
        end else begin
            sw_standby    <= 1'b0;
            hw_standby_sw <= 1'b0;
            if (pin_low) begin
                ram_control_reg <= `FPEP_RESET_VAL;
            end else if (wr_ok && avs_address == `FPEP_ADDR_RAM_CONTROL_REG) begin
                ram_control_reg <= wbyte & `FPEP_RC_WMASK;
            end
            if (wr_ok && avs_address == `FPEP_ADDR_EVENT) begin
                sw_standby    <= wbyte[`FPEP_EV_SWSTBY] | wbyte[`FPEP_EV_SLEEP];
                hw_standby_sw <= wbyte[`FPEP_EV_HWSTBY];
            end
        end
    end

    // ************************************************************
    // mode gating
    // ************************************************************
    wire hw_prot;
    wire sw_prot;
    wire any_block;
    assign hw_prot   = pin_low | standby | flash_error_flag | watchdog_timer_reset;
    assign sw_prot   = ram_overlay_select;
    assign any_block = |erase_block_select;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            program_mode        <= 1'b0;
            erase_mode          <= 1'b0;
            program_verify_mode <= 1'b0;
            erase_verify_mode   <= 1'b0;
            erase_enable        <= {NUM_BLOCKS{1'b0}};
        end else begin
            // error aborts the mode in the same cycle it is seen
            program_mode <= flash_control_reg_one[`FPEP_C1_P] & flash_write_enable_pin
                          & !hw_prot & !sw_prot & !error_event;
            erase_mode   <= flash_control_reg_one[`FPEP_C1_E] & flash_write_enable_pin
                          & !hw_prot & !sw_prot & any_block & !error_event;
            program_verify_mode <= flash_control_reg_one[`FPEP_C1_PV] & !pin_low
                                 & !standby;
            erase_verify_mode   <= flash_control_reg_one[`FPEP_C1_EV] & !pin_low
                                 & !standby;
            if (hw_prot || sw_prot) begin
                erase_enable <= {NUM_BLOCKS{1'b0}};
            end else begin
                erase_enable <= erase_block_select;
            end
        end
    end

    // ************************************************************
    // RAM overlay decode
    // ************************************************************
    function [2:0] fpep_sel;
        input [7:0] rc;
        begin
            fpep_sel = rc[`FPEP_RC_SEL_HI:`FPEP_RC_SEL_LO];
        end
    endfunction

    wire [13:0] win_idx;
    wire        overlay_on;
    assign win_idx = cpu_addr[23:`FPEP_WIN_SHIFT];
    // overlay exists only while the pin is high and ram select is set
    assign overlay_on = ram_overlay_select & flash_write_enable_pin;
    // flash window or original RAM window both reach the same cells
    wire ram_win;
    assign ram_win = (cpu_addr >= `FPEP_RAM_WIN_BASE) && (cpu_addr <= `FPEP_RAM_WIN_TOP);
    assign overlay_hit = overlay_on
        & ((win_idx == (SMALL_BLOCK_LO + {11'h000, fpep_sel(ram_control_reg)}))
        | ram_win);
    assign overlay_offset = cpu_addr[9:0];

    // ************************************************************
    // read data
    // ************************************************************
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
            rd_pending   <= 1'b0;
        end else begin
            rd_pending <= avs_read & !rd_pending;
            if (avs_read && !rd_pending) begin
                case (avs_address)
                    `FPEP_ADDR_CTRL1: avs_readdata <= {24'h000000,
                        flash_write_enable_pin, flash_control_reg_one[6:0]};
                    `FPEP_ADDR_CTRL2: avs_readdata <= {24'h000000, flash_control_reg_two};
                    `FPEP_ADDR_EBSEL: avs_readdata <= {{(32-NUM_BLOCKS){1'b0}},
                        erase_block_select};
                    `FPEP_ADDR_RAM_CONTROL_REG: avs_readdata <= {24'h000000, ram_control_reg};
                    default:          avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

/* bench/fpep_protect_properties.sv */
// concurrent checks on the flash protection block's ports
`timescale 1ns/1ps
module fpep_protect_properties #(
    parameter NUM_BLOCKS = 8
) (
    // clock, reset and bus
    input wire                  clock,
    input wire                  arst_n,
    input wire                  watchdog_timer_reset,
    input wire                  avs_read,
    input wire                  avs_write,
    input wire                  avs_waitrequest,
    // pins and cpu events
    input wire                  flash_write_enable_pin,
    input wire                  hw_standby,
    input wire                  flash_read,
    input wire                  exception_start,
    input wire                  exception_excluded,
    input wire                  sleep_exec,
    input wire                  bus_granted,
    input wire [23:0]           cpu_addr,
    // flash side
    input wire                  program_mode,
    input wire                  erase_mode,
    input wire                  program_verify_mode,
    input wire                  erase_verify_mode,
    input wire [NUM_BLOCKS-1:0] erase_enable,
    input wire                  nmi_out,
    input wire                  overlay_hit,
    input wire [9:0]            overlay_offset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire any_mode = program_mode | erase_mode;
    wire cause = flash_read | sleep_exec | bus_granted | (exception_start & ~exception_excluded);
    sequence s_fault;
        any_mode && cause;
    endsequence
    sequence s_pin_low;
        !flash_write_enable_pin [*3];
    endsequence
    sequence s_read_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    a_read_one_wait: assert property ($rose(avs_read) |-> s_read_answer)
        else $error("read answer timing wrong");
    a_fault_aborts: assert property (s_fault |=> !any_mode [*8])
        else $error("mode survived a fault");
    a_fault_nmi_off: assert property (s_fault |=> !nmi_out [*4])
        else $error("nmi passed in error state");
    a_mode_nmi_off: assert property (any_mode |-> !nmi_out)
        else $error("nmi passed during pulse");
    a_pin_low_idle: assert property (s_pin_low |-> !(any_mode | program_verify_mode
        | erase_verify_mode) && erase_enable == '0)
        else $error("mode with pin low");
    a_pin_drops_map: assert property (!flash_write_enable_pin [*2] |-> !overlay_hit)
        else $error("overlay kept with pin low");
    a_erase_needs_blk: assert property (erase_mode |-> erase_enable != '0)
        else $error("erase with no block");
    a_wdog_clears: assert property (watchdog_timer_reset |-> ##2 !any_mode
        && erase_enable == '0)
        else $error("watchdog reset left state");
    a_stby_clears: assert property (hw_standby |-> ##2 !any_mode)
        else $error("standby left mode");
    a_offset_follow: assert property (overlay_offset == cpu_addr[9:0])
        else $error("overlay offset wrong");
endmodule
bind fpep_protect fpep_protect_properties #(.NUM_BLOCKS(NUM_BLOCKS)) u_props (
    .clock, .arst_n, .watchdog_timer_reset, .avs_read, .avs_write, .avs_waitrequest,
    .flash_write_enable_pin, .hw_standby, .flash_read, .exception_start,
    .exception_excluded, .sleep_exec, .bus_granted, .cpu_addr, .program_mode,
    .erase_mode, .program_verify_mode, .erase_verify_mode, .erase_enable, .nmi_out,
    .overlay_hit, .overlay_offset);

/* bench/flash_program_erase_protection_test.sv */
// self-checking bench for the flash protection block
`timescale 1ns/1ps
`include "fpep_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module flash_program_erase_protection_test;
    logic        clock = 0;
    logic        arst_n = 0;
    logic        wdog = 0;
    logic [3:0]  addr = 0;
    logic        rd = 0;
    logic        wr = 0;
    logic [31:0] wdata = 0;
    logic [3:0]  ben = 4'h1;
    logic        pin = 1;
    logic        hw_standby = 0;
    logic [4:0]  ev = 0;
    logic        nmi_in = 1;
    logic [23:0] cpu_addr = 0;
    wire  [31:0] rdata;
    wire         wait_req, pm, em, pvm, evm, nmi_out, hit;
    wire  [7:0]  erase_en;
    wire  [9:0]  offset;
    logic [31:0] q;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    int          i;
    fpep_protect u_dut (
        .clock(clock), .arst_n(arst_n), .watchdog_timer_reset(wdog),
        .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(ben), .avs_readdata(rdata), .avs_waitrequest(wait_req),
        .flash_write_enable_pin(pin), .hw_standby(hw_standby), .flash_read(ev[0]),
        .exception_start(ev[1]), .sleep_exec(ev[2]), .bus_granted(ev[3]),
        .exception_excluded(ev[4]), .nmi_in(nmi_in), .cpu_addr(cpu_addr),
        .program_mode(pm), .erase_mode(em), .program_verify_mode(pvm),
        .erase_verify_mode(evm), .erase_enable(erase_en), .nmi_out(nmi_out),
        .overlay_hit(hit), .overlay_offset(offset));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    // one avalon-mm transfer; waitrequest and data taken at the same rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] b = 4'h1);
        @(posedge clock);
        addr <= a;
        wdata <= {24'h0, d};
        ben <= b;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clock);
        end while (wait_req !== 1'b0 && cycles < 20000);
        q = rdata;
        wr <= 0;
        rd <= 0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        bus(0, a, 8'h00);
        `CHK(q, {24'h0, e})
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge clock);
        ev <= m;
        @(posedge clock);
        ev <= 0;
        @(negedge clock);
    endtask
    task automatic go_prog();
        bus(1, `FPEP_ADDR_CTRL1, 8'h40);
        bus(1, `FPEP_ADDR_CTRL1, 8'h50);
        bus(1, `FPEP_ADDR_CTRL1, 8'h51);
        wt(2);
    endtask
    task automatic set_pin(input logic v);
        @(posedge clock);
        pin <= v;
        wt(3);
    endtask
    task automatic ov(input logic [23:0] a, input logic e);
        @(posedge clock);
        cpu_addr <= a;
        wt(0);
        `CHK(hit, e)
    endtask
    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1;
        wt(4);
        rchk(`FPEP_ADDR_CTRL1, 8'h80);
        rchk(`FPEP_ADDR_CTRL2, 8'h00);
        rchk(4'h9, 8'h00);
        bus(1, `FPEP_ADDR_CTRL1, 8'h40, 4'h0);
        rchk(`FPEP_ADDR_CTRL1, 8'h80);
        for (i = 0; i < 5; i++) begin
            go_prog();
            `CHK({pm, nmi_out}, 2'b10)
            pulse(i == 4 ? 5'h12 : 5'h01 << i);
            wt(1);
            `CHK(pm, i == 4)
            rchk(`FPEP_ADDR_CTRL2, i == 4 ? 8'h00 : 8'h80);
            if (i == 0) begin
                rchk(`FPEP_ADDR_CTRL1, 8'hd1);
                bus(1, `FPEP_ADDR_CTRL2, 8'h00);
                rchk(`FPEP_ADDR_CTRL2, 8'h80);
                bus(1, `FPEP_ADDR_CTRL1, 8'h55);
                wt(2);
                `CHK({pm, pvm, nmi_out}, 3'b010)
                bus(1, `FPEP_ADDR_EVENT, 8'h01);
                rchk(`FPEP_ADDR_CTRL1, 8'h80);
                rchk(`FPEP_ADDR_CTRL2, 8'h80);
            end
            @(posedge clock);
            wdog <= 1;
            @(posedge clock);
            wdog <= 0;
            wt(3);
            rchk(`FPEP_ADDR_CTRL2, 8'h00);
            rchk(`FPEP_ADDR_CTRL1, 8'h80);
        end
        bus(1, `FPEP_ADDR_CTRL1, 8'h40);
        bus(1, `FPEP_ADDR_CTRL1, 8'h60);
        bus(1, `FPEP_ADDR_CTRL1, 8'h62);
        wt(2);
        `CHK(em, 1'b0)
        bus(1, `FPEP_ADDR_EBSEL, 8'h04);
        bus(1, `FPEP_ADDR_CTRL1, 8'h62);
        wt(2);
        `CHK({em, erase_en}, 9'h104)
        set_pin(0);
        `CHK({em, pvm, evm, erase_en}, 11'h000)
        rchk(`FPEP_ADDR_CTRL1, 8'h00);
        rchk(`FPEP_ADDR_EBSEL, 8'h00);
        set_pin(1);
        bus(1, `FPEP_ADDR_RAM_CONTROL_REG, 8'h0a);
        ov(24'hfff010, 1'b1);
        ov(24'h000810, 1'b1);
        ov(24'h000410, 1'b0);
        go_prog();
        `CHK(pm, 1'b0)
        set_pin(0);
        ov(24'hfff010, 1'b0);
        rchk(`FPEP_ADDR_RAM_CONTROL_REG, 8'h00);
        set_pin(1);
        go_prog();
        pulse(5'h08);
        @(posedge clock);
        hw_standby <= 1;
        repeat (2) @(posedge clock);
        hw_standby <= 0;
        wt(2);
        rchk(`FPEP_ADDR_CTRL2, 8'h00);
        go_prog();
        @(posedge clock);
        arst_n <= 0;
        wt(20);
        `CHK(pm, 1'b0)
        @(posedge clock);
        arst_n <= 1;
        wt(4);
        rchk(`FPEP_ADDR_CTRL1, 8'h80);
        summarize();
    end
endmodule
